// file: bench/ahp_chk_sva.sv
// ahp_chk_sva: timing checks on the cable between host and device ends.
// assumes both ends share clk; inputs come straight from the ahp_if signals.
`timescale 1ns/100ps
module ahp_chk_sva
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic cs0_n,
   input wire logic cs1_n,
   input wire logic [ahp_pkg::ADDR_W-1:0] da,
   input wire logic dd_oe,
   input wire logic iordy,
   input wire logic dmarq,
   input wire logic dmack_n,
   input wire logic intrq_o,
   input wire logic stop,
   input wire logic hdmardy_n,
   input wire logic hstrobe,
   input wire logic ddmardy_n,
   input wire logic dstrobe,
   input wire logic pdiag_o,
   input wire logic pdiag_oe
);
   import ahp_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // status read and command write, as seen on the pins
   sequence s_stat_rd;
      $fell(rd_n) && !cs0_n && cs1_n && da == ADDR_STATUS;
   endsequence
   sequence s_cmd_wr;
      $fell(wr_n) && !cs0_n && cs1_n && da == ADDR_STATUS;
   endsequence
   // paused bursts: the ready line held high long enough to pass sync stages
   sequence s_in_paused;
      (!dmack_n && !stop && hdmardy_n) [*6];
   endsequence
   sequence s_out_paused;
      (!dmack_n && !stop && ddmardy_n) [*6];
   endsequence
   AST_RD_DRIVE: assert property ($rose(dd_oe) && dmack_n |-> !rd_n)
      else $error("data bus driven without read strobe");
   AST_STAT_CLR: assert property (s_stat_rd |-> ##[1:16] !intrq_o)
      else $error("irq kept after status read");
   AST_CMD_CLR: assert property (s_cmd_wr |-> ##[1:16] !intrq_o)
      else $error("irq kept after command write");
   AST_IN_PAUSE: assert property (s_in_paused |=> $stable(dstrobe))
      else $error("device strobe moved while host not ready");
   AST_OUT_PAUSE: assert property (s_out_paused |=> $stable(hstrobe))
      else $error("host strobe moved while device not ready");
   AST_DMARQ_DROP: assert property ($fell(dmack_n) |-> ##[1:8] !dmarq)
      else $error("dma request kept after acknowledge");
   AST_IORDY_HOLD: assert property (!iordy && !(rd_n && wr_n) |=> $stable({rd_n, wr_n}))
      else $error("host strobe released while io ready low");
   AST_IORDY_LEN: assert property ($fell(iordy) |-> !iordy [*4])
      else $error("io ready stretch too short");
   AST_PDIAG_LOW: assert property (pdiag_oe |-> !pdiag_o)
      else $error("diag line driven high");
endmodule // ahp_chk_sva

// file: bench/tb_top.sv
// tb_top: drives user sides of host and device ends, judges the cable.
// assumes one 40 MHz clock for both ends; no model of either end.
`timescale 1ns/100ps
module tb_top;
   import ahp_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic is_slave, busy, irq_set, sector_done, diag_done, xfer_ready, d_in_valid;
   logic [15:0] d_in_data = 16'h5A00; // next word the device offers
   logic [15:0] h_out_word = 16'hA000; // next word the host offers
   logic d_in_taken, d_out_valid, cmd_valid, slave_seen, cable_80;
   logic [15:0] d_out_data;
   logic [7:0] cmd_data;
   logic req, req_wr, req_cs1, req_done, burst_in, burst_out, burst_stop, host_ready;
   logic h_out_valid, h_out_taken, h_in_valid, cable_sel_80;
   logic [2:0] req_addr;
   logic [15:0] req_wdata, rdata, h_in_word;
   logic [15:0] outq[$], inq[$], cmdq[$]; // words seen at the user sides
   int fails = 0;
   int compares = 0;
   ahp_if bus_if ();
   ahp_dev u_ahp_dev (.clk(clk), .rst(rst), .bus(bus_if.dev), .is_slave(is_slave), .busy(busy),
      .irq_set(irq_set), .sector_done(sector_done), .diag_done(diag_done), .xfer_ready(xfer_ready),
      .in_data(d_in_data), .in_valid(d_in_valid), .in_taken(d_in_taken), .out_data(d_out_data),
      .out_valid(d_out_valid), .cmd_data(cmd_data), .cmd_valid(cmd_valid), .slave_seen(slave_seen),
      .cable_80(cable_80));
   ahp_host u_ahp_host (.clk(clk), .rst(rst), .bus(bus_if.host), .req(req), .req_wr(req_wr),
      .req_cs1(req_cs1), .req_addr(req_addr), .req_wdata(req_wdata), .req_done(req_done), .rdata(rdata),
      .burst_in(burst_in), .burst_out(burst_out), .burst_stop(burst_stop), .host_ready(host_ready),
      .out_word(h_out_word), .out_valid(h_out_valid), .out_taken(h_out_taken), .in_word(h_in_word),
      .in_valid(h_in_valid), .cable_sel_80(cable_sel_80));
   ahp_chk_sva u_chk (.clk(clk), .rst(rst), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .cs0_n(bus_if.cs0_n),
      .cs1_n(bus_if.cs1_n), .da(bus_if.da), .dd_oe(bus_if.dd_oe), .iordy(bus_if.iordy), .dmarq(bus_if.dmarq),
      .dmack_n(bus_if.dmack_n), .intrq_o(bus_if.intrq_o), .stop(bus_if.stop), .hdmardy_n(bus_if.hdmardy_n),
      .hstrobe(bus_if.hstrobe), .ddmardy_n(bus_if.ddmardy_n), .dstrobe(bus_if.dstrobe),
      .pdiag_o(bus_if.pdiag_o), .pdiag_oe(bus_if.pdiag_oe));
   always #12.5 clk = ~clk;
   // collect delivered words; advance each source only when its word is taken
   always @(posedge clk)
   begin
      if (d_out_valid === 1'b1) outq.push_back(d_out_data);
      if (h_in_valid === 1'b1) inq.push_back(h_in_word);
      if (cmd_valid === 1'b1) cmdq.push_back({8'h00, cmd_data});
      if (h_out_taken === 1'b1) h_out_word <= h_out_word + 16'h0001;
      if (d_in_taken === 1'b1) d_in_data <= d_in_data + 16'h0001;
   end
   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a wait that ran out is a mismatch and ends the run
   task automatic give_up();
      fails++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report();
   endtask
   // inputs change one time unit after the edge, never on it
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick();
      s = 0;
      tick(4);
   endtask
   // one register cycle: request held until done, cycles counted
   task automatic host_op(input logic wr, input logic cs1, input logic [2:0] a, input logic [15:0] wd,
      output int n);
      n = 0;
      req = 1; req_wr = wr; req_cs1 = cs1; req_addr = a; req_wdata = wd;
      while (req_done !== 1'b1 && n < 300)
      begin
         tick();
         n++;
      end
      if (n >= 300) give_up();
      req = 0;
      tick();
   endtask
   task automatic wait_words(input bit dir_in, input int sz);
      int n;
      n = 0;
      while ((dir_in ? inq.size() : outq.size()) < sz && n < 3000)
      begin
         tick();
         n++;
      end
      if (n >= 3000) give_up();
   endtask
   task automatic t_read();
      int c0, c1;
      pulse(irq_set);
      check(bus_if.intrq, 1);
      host_op(0, 0, ADDR_STATUS, 16'h0000, c0);
      check(rdata, {8'h00, STATUS_IDLE});
      check(bus_if.intrq, 0);
      busy = 1;
      host_op(0, 0, ADDR_STATUS, 16'h0000, c1);
      busy = 0;
      check(16'(c1 >= c0 + IORDY_WAIT), 1);
      $display("test read done");
   endtask
   task automatic t_cmd();
      int c;
      pulse(irq_set);
      host_op(1, 0, ADDR_STATUS, 16'h00EC, c);
      tick(4);
      check(16'(cmdq.size()), 1);
      check(cmdq[0], 16'h00EC);
      check(bus_if.intrq_o, 0);
      // same address in the control block is no command
      host_op(1, 1, 3'h7, 16'h0091, c);
      tick(4);
      check(16'(cmdq.size()), 1);
      $display("test command done");
   endtask
   task automatic t_ctrl();
      int c;
      pulse(irq_set);
      pulse(sector_done);
      check(bus_if.intrq_o, 0);
      pulse(irq_set);
      host_op(1, 1, ADDR_CTRL, 16'h0002, c);
      check(bus_if.intrq_oe, 0);
      host_op(1, 1, ADDR_CTRL, 16'h0004, c);
      tick(4);
      check(bus_if.intrq_o, 0);
      host_op(1, 1, ADDR_CTRL, 16'h0000, c);
      host_op(1, 0, ADDR_DEVHEAD, 16'h0010, c);
      check(bus_if.intrq_oe, 0);
      host_op(1, 0, ADDR_DEVHEAD, 16'h0000, c);
      check(bus_if.intrq_oe, 1);
      $display("test control done");
   endtask
   task automatic t_out();
      int n;
      xfer_ready = 1;
      tick(6);
      check(bus_if.dmarq, 1);
      burst_out = 1; h_out_valid = 1;
      wait_words(0, 4);
      h_out_valid = 0;
      tick(30);
      n = outq.size();
      tick(30);
      check(16'(outq.size()), 16'(n));
      h_out_valid = 1;
      wait_words(0, n + 4);
      // device pauses by negating its ready; the host must stop strobing
      xfer_ready = 0;
      tick(15);
      n = outq.size();
      tick(30);
      check(16'(outq.size()), 16'(n));
      xfer_ready = 1;
      wait_words(0, n + 4);
      burst_stop = 1;
      tick(20);
      burst_out = 0; h_out_valid = 0; xfer_ready = 0;
      tick(20);
      burst_stop = 0;
      foreach (outq[i]) check(outq[i], 16'hA000 + 16'(i));
      $display("test data out done");
   endtask
   task automatic t_in();
      int n;
      xfer_ready = 1; d_in_valid = 1; host_ready = 1; burst_in = 1;
      wait_words(1, 4);
      host_ready = 0;
      tick(15);
      n = inq.size();
      tick(30);
      check(16'(inq.size()), 16'(n));
      host_ready = 1;
      wait_words(1, n + 4);
      burst_stop = 1;
      tick(20);
      // stop still raised with words offered: nothing more may arrive
      n = inq.size();
      tick(20);
      check(16'(inq.size()), 16'(n));
      burst_in = 0; d_in_valid = 0; xfer_ready = 0;
      tick(20);
      burst_stop = 0;
      foreach (inq[i]) check(inq[i], 16'h5A00 + 16'(i));
      $display("test data in done");
   endtask
   task automatic t_side();
      check(cable_80, 1);
      check(slave_seen, 0);
      is_slave = 1;
      tick(6);
      check(bus_if.dasp_n, 0);
      pulse(diag_done);
      tick(4);
      check(bus_if.pdiag_oe, 1);
      check(bus_if.pdiag_n, 0);
      $display("test sideband done");
   endtask
   initial
   begin
      is_slave = 0; busy = 0; irq_set = 0; sector_done = 0; diag_done = 0; xfer_ready = 0;
      d_in_valid = 0; req = 0; req_wr = 0; req_cs1 = 0; req_addr = 3'h0; req_wdata = 16'h0000;
      burst_in = 0; burst_out = 0; burst_stop = 0; host_ready = 0; h_out_valid = 0;
      tick(10);
      rst = 0;
      tick(3);
      t_read();
      t_cmd();
      t_ctrl();
      t_out();
      t_in();
      t_side();
      final_report();
   end
endmodule // tb_top

// file: rtl/ahp_dev.sv
// ahp_dev: device end of the port: task file, irq, udma both ways, sideband.
// assumes host pins are asynchronous; user side is on clk.
`timescale 1ns/100ps
module ahp_dev
(
   input wire logic clk,
   input wire logic rst,
   ahp_if.dev bus,
   input wire logic is_slave,
   input wire logic busy,
   input wire logic irq_set,
   input wire logic sector_done,
   input wire logic diag_done,
   input wire logic xfer_ready,
   input wire logic [ahp_pkg::DATA_W-1:0] in_data,
   input wire logic in_valid,
   output logic in_taken,
   output logic [ahp_pkg::DATA_W-1:0] out_data,
   output logic out_valid,
   output logic [7:0] cmd_data,
   output logic cmd_valid,
   output logic slave_seen,
   output logic cable_80
);
   import ahp_pkg::*;
   // two-flop synchronisers for every host pin
   localparam int NS = 9;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   logic [NS-1:0] p_reg;
   logic [DATA_W-1:0] d1_reg;
   logic [DATA_W-1:0] d2_reg;
   logic [ADDR_W-1:0] a1_reg;
   logic [ADDR_W-1:0] a2_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_reg <= '1;
         s2_reg <= '1;
         p_reg <= '1;
         d1_reg <= '0;
         d2_reg <= '0;
         a1_reg <= '0;
         a2_reg <= '0;
      end
      else
      begin
         s1_reg <= {bus.cblid_n, bus.pdiag_n, bus.hstrobe, bus.hdmardy_n, bus.stop, bus.dmack_n,
                    bus.cs1_n, bus.cs0_n, bus.rd_n & bus.wr_n};
         s2_reg <= s1_reg;
         p_reg <= s2_reg;
         d1_reg <= bus.dd;
         d2_reg <= d1_reg;
         a1_reg <= bus.da;
         a2_reg <= a1_reg;
      end
   end
   logic rd_n_s;
   logic cs0_s;
   logic cs1_s;
   logic ack_s;
   logic stop_s;
   logic hrdy_s;
   logic hstb_s;
   logic hstb_p;
   logic rd_fall;
   logic wr_fall;
   logic wr_s;
   logic [1:0] rw1_reg;
   logic [1:0] rw2_reg;
   logic [1:0] rwp_reg;
   // separate read/write sync so strobe type is known
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rw1_reg <= 2'h3;
         rw2_reg <= 2'h3;
         rwp_reg <= 2'h3;
      end
      else
      begin
         rw1_reg <= {bus.wr_n, bus.rd_n};
         rw2_reg <= rw1_reg;
         rwp_reg <= rw2_reg;
      end
   end
   assign rd_n_s = rw2_reg[0];
   assign wr_s = !rw2_reg[1];
   assign rd_fall = !rw2_reg[0] && rwp_reg[0];
   assign wr_fall = !rw2_reg[1] && rwp_reg[1];
   assign cs0_s = !s2_reg[1];
   assign cs1_s = !s2_reg[2];
   assign ack_s = !s2_reg[3];
   assign stop_s = s2_reg[4];
   assign hrdy_s = !s2_reg[5];
   assign hstb_s = s2_reg[6];
   assign hstb_p = p_reg[6];
   // task file state
   logic [7:0] ctrl_reg;
   logic dev_reg;
   logic irq_reg;
   logic selected;
   assign selected = (dev_reg == is_slave);
   // command block only with first select
   logic cmd_hit;
   assign cmd_hit = cs0_s && !cs1_s;
   // control block only with second select
   logic ctl_hit;
   assign ctl_hit = cs1_s && !cs0_s && (a2_reg == ADDR_CTRL);
   // register writes; address picks register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg <= '0;
         dev_reg <= 1'b0;
         cmd_data <= '0;
         cmd_valid <= 1'b0;
      end
      else
      begin
         cmd_valid <= 1'b0;
         if (wr_fall && cmd_hit && a2_reg == ADDR_STATUS)
         begin
            cmd_data <= d2_reg[7:0];
            cmd_valid <= 1'b1;
         end
         else if (wr_fall && cmd_hit && a2_reg == ADDR_DEVHEAD)
            dev_reg <= d2_reg[DEV_BIT];
         else if (wr_fall && ctl_hit)
            ctrl_reg <= d2_reg[7:0];
      end
   end
   // negation causes; sector completion clears too; set wins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_reg <= 1'b0;
      else if (irq_set)
         irq_reg <= 1'b1;
      else if (ctrl_reg[CTRL_SRST_BIT] || sector_done || (cmd_hit && a2_reg == ADDR_STATUS && (rd_fall || wr_fall)))
         irq_reg <= 1'b0;
   end
   // float irq when unselected or disabled
   assign bus.intrq_oe = selected && !ctrl_reg[CTRL_NIEN_BIT];
   assign bus.intrq_o = irq_reg;
   logic [3:0] wait_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wait_reg <= '0;
      else if ((rd_fall || wr_fall) && (cmd_hit || ctl_hit))
         wait_reg <= busy ? 4'(IORDY_WAIT) : 4'h0;
      else if (wait_reg != 4'h0)
         wait_reg <= wait_reg - 4'h1;
   end
   assign bus.iordy = (wait_reg == 4'h0);
   // drive register data while read strobe low
   logic [DATA_W-1:0] rdata_reg;
   logic rd_oe_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_reg <= '0;
         rd_oe_reg <= 1'b0;
      end
      else
      begin
         rd_oe_reg <= !rd_n_s && selected && (cmd_hit || ctl_hit);
         rdata_reg <= (a2_reg == ADDR_STATUS || ctl_hit) ? {8'h00, STATUS_IDLE} : in_data;
      end
   end
   // dma request up when ready, down on ack
   assign bus.dmarq = xfer_ready && !ack_s;
   // udma data-in: toggle strobe per word, pause, ready
   logic dstb_reg;
   logic [DATA_W-1:0] udata_reg;
   logic [2:0] pace_reg;
   logic din_go;
   assign din_go = ack_s && !stop_s && hrdy_s && in_valid && pace_reg == 3'h0;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dstb_reg <= 1'b0;
         udata_reg <= '0;
         pace_reg <= '0;
      end
      else if (!ack_s || stop_s)
         pace_reg <= '0;
      else if (din_go)
      begin
         udata_reg <= in_data;
         dstb_reg <= !dstb_reg;
         pace_reg <= 3'(HOST_HALF);
      end
      else if (pace_reg != 3'h0)
         pace_reg <= pace_reg - 3'h1;
   end
   assign in_taken = din_go;
   assign bus.dstrobe = dstb_reg;
   // burst direction comes from the user side: with no word offered the host owns the bus,
   // so the device fights a data-out burst, whose strobe shares the read pin, whenever in_valid is high
   function automatic logic is_write_burst(input logic offered);
      return !offered;
   endfunction
   assign bus.dd_o = ack_s ? udata_reg : rdata_reg;
   assign bus.dd_oe = rd_oe_reg || (ack_s && !stop_s && !is_write_burst(in_valid));
   // ready low when able; negate to pause
   assign bus.ddmardy_n = !(ack_s && xfer_ready && !stop_s);
   // capture on both host strobe edges; no edge is just a pause
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         out_data <= '0;
         out_valid <= 1'b0;
      end
      else
      begin
         out_valid <= ack_s && !stop_s && (hstb_s != hstb_p);
         out_data <= d2_reg;
      end
   end
   // slave drives diag, master listens; assert when done
   logic diag_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         diag_reg <= 1'b0;
      else if (diag_done)
         diag_reg <= 1'b1;
   end
   assign bus.pdiag_oe = is_slave && diag_reg;
   assign bus.pdiag_o = 1'b0;
   assign slave_seen = !is_slave && !s2_reg[7];
   assign cable_80 = !s2_reg[8];
   // activity: slave shows presence, master blinks while busy
   logic [5:0] blink_reg;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         blink_reg <= '0;
      else
         blink_reg <= blink_reg + 6'h1;
   end
   assign bus.dasp_oe = is_slave ? !diag_reg : (busy && blink_reg[5]);
   assign bus.dasp_o = 1'b0;
   // wr_s kept for stretch observation
   logic unused_wr;
   assign unused_wr = wr_s;
endmodule // ahp_dev

// file: rtl/ahp_host.sv
// ahp_host: host end: register cycles, udma flow control, cable id drive.
// assumes device pins asynchronous; commands come from user logic on clk.
`timescale 1ns/100ps
module ahp_host
(
   input wire logic clk,
   input wire logic rst,
   ahp_if.host bus,
   input wire logic req,
   input wire logic req_wr,
   input wire logic req_cs1,
   input wire logic [ahp_pkg::ADDR_W-1:0] req_addr,
   input wire logic [ahp_pkg::DATA_W-1:0] req_wdata,
   output logic req_done,
   output logic [ahp_pkg::DATA_W-1:0] rdata,
   input wire logic burst_in,
   input wire logic burst_out,
   input wire logic burst_stop,
   input wire logic host_ready,
   input wire logic [ahp_pkg::DATA_W-1:0] out_word,
   input wire logic out_valid,
   output logic out_taken,
   output logic [ahp_pkg::DATA_W-1:0] in_word,
   output logic in_valid,
   output logic cable_sel_80
);
   import ahp_pkg::*;
   typedef enum {IDLE, STRB, WAIT, DONE} ahp_hst_t;
   ahp_hst_t st_reg;
   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [3:0] p_reg;
   logic [DATA_W-1:0] d1_reg;
   logic [DATA_W-1:0] d2_reg;
   logic [2:0] cnt_reg;
   logic hstb_reg;
   logic [DATA_W-1:0] wd_reg;
   // synchronise device pins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         p_reg <= '0;
         d1_reg <= '0;
         d2_reg <= '0;
      end
      else
      begin
         s1_reg <= {bus.dmarq, bus.ddmardy_n, bus.dstrobe, bus.iordy};
         s2_reg <= s1_reg;
         p_reg <= s2_reg;
         d1_reg <= bus.dd;
         d2_reg <= d1_reg;
      end
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= IDLE;
         cnt_reg <= '0;
         rdata <= '0;
      end
      else
         case (st_reg)
            IDLE:
               if (req && !burst_in && !burst_out)
               begin
                  st_reg <= STRB;
                  cnt_reg <= 3'(HOST_HALF);
               end
            STRB:
               if (cnt_reg != 3'h0)
                  cnt_reg <= cnt_reg - 3'h1;
               else
                  st_reg <= WAIT;
            // hold strobe until io ready returns
            WAIT:
               if (s2_reg[0])
               begin
                  rdata <= d2_reg;
                  st_reg <= DONE;
               end
            DONE:
               st_reg <= IDLE;
            default:
               st_reg <= IDLE;
         endcase
   end
   logic cyc;
   assign cyc = (st_reg == STRB) || (st_reg == WAIT);
   assign req_done = (st_reg == DONE);
   assign bus.cs0_n = !(cyc && !req_cs1);
   assign bus.cs1_n = !(cyc && req_cs1);
   assign bus.da = req_addr;
   // stop negated during burst, raised to end it
   assign bus.dmack_n = !(burst_in || burst_out);
   assign bus.stop = burst_stop;
   // host ready shares the read pin in data-in bursts
   assign bus.rd_n = burst_in ? !host_ready : (burst_out ? hstb_reg : !(cyc && !req_wr));
   assign bus.hdmardy_n = !host_ready;
   assign bus.wr_n = !(cyc && req_wr);
   // send word only while device ready; toggle strobe
   assign out_taken = burst_out && !burst_stop && !s2_reg[2] && out_valid && cnt_reg == 3'h0 && st_reg == IDLE;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hstb_reg <= 1'b1;
         wd_reg <= '0;
      end
      else if (out_taken)
      begin
         wd_reg <= out_word;
         hstb_reg <= !hstb_reg;
      end
      else if (st_reg == IDLE && !req)
         wd_reg <= req_wr ? req_wdata : wd_reg;
   end
   assign bus.hstrobe = hstb_reg;
   assign bus.dh_o = burst_out ? wd_reg : req_wdata;
   assign bus.dh_oe = burst_out || (cyc && req_wr);
   // latch data on both device strobe edges
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         in_word <= '0;
         in_valid <= 1'b0;
      end
      else
      begin
         in_valid <= burst_in && (s2_reg[1] != p_reg[1]);
         in_word <= d2_reg;
      end
   end
   // host grounds cable id for 80-conductor
   assign bus.cblid_n = !cable_sel_80;
   assign cable_sel_80 = 1'b1;
endmodule // ahp_host

// file: rtl/ahp_if.sv
// ahp_if: the cable between host and device, one modport for each end.
// assumes both ends share clk-domain style signals; open pins resolved here.
`timescale 1ns/100ps
interface ahp_if;
   import ahp_pkg::*;
   logic rd_n;
   logic wr_n;
   logic cs0_n;
   logic cs1_n;
   logic [ADDR_W-1:0] da;
   logic [DATA_W-1:0] dh_o;
   logic dh_oe;
   logic [DATA_W-1:0] dd_o;
   logic dd_oe;
   logic [DATA_W-1:0] dd;
   logic iordy;
   logic dmarq;
   logic dmack_n;
   logic intrq_o;
   logic intrq_oe;
   logic intrq;
   logic stop;
   logic hdmardy_n;
   logic hstrobe;
   logic ddmardy_n;
   logic dstrobe;
   logic pdiag_o;
   logic pdiag_oe;
   logic pdiag_n;
   logic cblid_n;
   logic dasp_o;
   logic dasp_oe;
   logic dasp_n;
   // wire resolution: data and irq read low where undriven, diag and activity pulled up
   assign dd = dd_oe ? dd_o : (dh_oe ? dh_o : '0);
   assign intrq = intrq_oe ? intrq_o : 1'b0;
   assign pdiag_n = pdiag_oe ? pdiag_o : 1'b1;
   assign dasp_n = dasp_oe ? dasp_o : 1'b1;
   modport dev (input rd_n, wr_n, cs0_n, cs1_n, da, dd, dmack_n, stop, hdmardy_n, hstrobe, pdiag_n, cblid_n,
      output dd_o, dd_oe, iordy, dmarq, intrq_o, intrq_oe, ddmardy_n, dstrobe, pdiag_o, pdiag_oe, dasp_o, dasp_oe);
   modport host (output rd_n, wr_n, cs0_n, cs1_n, da, dh_o, dh_oe, dmack_n, stop, hdmardy_n, hstrobe, cblid_n,
      input dd, iordy, dmarq, intrq, ddmardy_n, dstrobe, pdiag_n, dasp_n);
endinterface

// file: rtl/ahp_pkg.sv
// ahp_pkg: shared constants for the parallel disk host port, both ends.
// assumes one 40 MHz clock per end; the cable is modelled by ahp_if.
package ahp_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 3;
   // register addresses inside each block
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h7;
   localparam logic [2:0] ADDR_CTRL = 3'h6;
   // soft reset and irq-disable bits of device control
   localparam int CTRL_SRST_BIT = 2;
   localparam int CTRL_NIEN_BIT = 1;
   // bit 4 of device/head selects the second drive
   localparam int DEV_BIT = 4;
   localparam logic [2:0] ADDR_DEVHEAD = 3'h6;
   // io ready stretch, in cycles
   localparam int IORDY_WAIT = 4;
   // host register strobe count and device data-in strobe pace, in clk cycles
   localparam int HOST_HALF = 4;
   // activity blink period for the multiplexed line
   localparam int DASP_PERIOD = 64;
   // status value shown by the device
   localparam logic [7:0] STATUS_IDLE = 8'h50;
endpackage
